// ===== verilog/bcpu_pkg.sv
`default_nettype none
package bcpu_pkg;
	// ****************************************
	// register map, byte addresses
	// ****************************************
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_SEG_CS = 8'h04;
	localparam logic [7:0] REG_SEG_DS = 8'h08;
	localparam logic [7:0] REG_SEG_ES = 8'h0C;
	localparam logic [7:0] REG_SEG_SS = 8'h10;
	localparam logic [7:0] REG_REQ    = 8'h14;
	localparam logic [7:0] REG_WDATA  = 8'h18;
	localparam logic [7:0] REG_RDATA  = 8'h1C;
	localparam logic [7:0] REG_STATUS = 8'h20;
	localparam logic [7:0] REG_PHYS   = 8'h24;
	localparam logic [7:0] REG_IP     = 8'h28;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL_LOCK_BIT = 0;
	localparam int CTRL_DONE_BIT = 1;
	localparam int CTRL_QOP_LSB  = 4;
	localparam int REQ_KIND_LSB  = 16;
	localparam int REQ_WORD_BIT  = 19;
	localparam int REQ_WR_BIT    = 20;
	localparam int REQ_OVR_BIT   = 21;
	localparam int REQ_OSEL_LSB  = 22;
	localparam int REQ_W         = 24;

	// ****************************************
	// reference kinds, segment codes, cycle and queue codes
	// ****************************************
	localparam logic [2:0] KIND_FETCH  = 3'h0;
	localparam logic [2:0] KIND_STACK  = 3'h1;
	localparam logic [2:0] KIND_FRAME  = 3'h2;
	localparam logic [2:0] KIND_DATA   = 3'h3;
	localparam logic [2:0] KIND_STRDST = 3'h4;
	localparam logic [2:0] KIND_IO     = 3'h5;
	localparam logic [2:0] KIND_VECTOR = 3'h6;
	localparam logic [1:0] SEG_ES = 2'h0;
	localparam logic [1:0] SEG_SS = 2'h1;
	localparam logic [1:0] SEG_CS = 2'h2;
	localparam logic [1:0] SEG_DS = 2'h3;
	localparam logic [2:0] CT_IO_RD   = 3'h1;
	localparam logic [2:0] CT_IO_WR   = 3'h2;
	localparam logic [2:0] CT_FETCH   = 3'h4;
	localparam logic [2:0] CT_MEM_RD  = 3'h5;
	localparam logic [2:0] CT_MEM_WR  = 3'h6;
	localparam logic [2:0] CT_PASSIVE = 3'h7;
	localparam logic [1:0] Q_NOP = 2'h0;

	// ****************************************
	// reset values and reserved areas
	// ****************************************
	localparam logic [15:0] RESET_CS    = 16'hFFFF;
	localparam logic [15:0] RESET_IP    = 16'h0000;
	localparam logic [19:0] RESET_ENTRY = 20'hF_FFF0;
	localparam logic [19:0] VEC_TOP     = 20'h0_03FF;

	typedef enum logic [4:0] {
		BCPU_S_IDLE = 5'h01,
		BCPU_S_T1   = 5'h02,
		BCPU_S_T2   = 5'h04,
		BCPU_S_T3   = 5'h08,
		BCPU_S_T4   = 5'h10
	} bcpu_state_t;
endpackage
`default_nettype wire

// ===== verilog/bcpu_seg_addr.sv
`timescale 1ns/1ps
`default_nettype none
module bcpu_seg_addr import bcpu_pkg::*; (
	input  wire logic [2:0]  kind,
	input  wire logic        ovr_en,
	input  wire logic [1:0]  ovr_seg,
	input  wire logic [15:0] seg_cs,
	input  wire logic [15:0] seg_ds,
	input  wire logic [15:0] seg_es,
	input  wire logic [15:0] seg_ss,
	input  wire logic [15:0] offset,
	input  wire logic [15:0] ip,
	output logic      [19:0] phys
);
	logic [1:0]  seg_used;
	logic [15:0] base;
	logic [15:0] off;

	always_comb begin
		seg_used = SEG_DS;
		off      = offset;
		case (kind)
			KIND_FETCH: begin
				seg_used = SEG_CS;
				off      = ip;
			end
			KIND_STACK:  seg_used = SEG_SS;
			KIND_FRAME:  seg_used = ovr_en ? ovr_seg : SEG_SS;
			KIND_STRDST: seg_used = SEG_ES;
			default:     seg_used = ovr_en ? ovr_seg : SEG_DS;
		endcase
		case (seg_used)
			SEG_ES:  base = seg_es;
			SEG_SS:  base = seg_ss;
			SEG_CS:  base = seg_cs;
			default: base = seg_ds;
		endcase
		// base moves four places so every segment starts on a paragraph
		phys = {base, 4'h0} + {4'h0, off};
		if (kind == KIND_IO) begin
			phys = {4'h0, offset};
		end else if (kind == KIND_VECTOR) begin
			// four bytes per entry, type in offset low byte
			phys = {10'h000, offset[7:0], 2'h0};
		end
	end
endmodule
`default_nettype wire

// ===== verilog/bcpu_cycle_seq.sv
`timescale 1ns/1ps
`default_nettype none
module bcpu_cycle_seq import bcpu_pkg::*; (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        start,
	input  wire logic [19:0] base,
	input  wire logic [2:0]  nbytes,
	input  wire logic        is_wr,
	input  wire logic        is_io,
	input  wire logic        is_fetch,
	input  wire logic [15:0] wdata,
	input  wire logic        max_mode,
	input  wire logic        ready_s,
	input  wire logic [7:0]  din_s,
	output logic             busy,
	output logic             done_q,
	output logic      [31:0] rbuf_q,
	output logic      [19:0] addr_q,
	output logic      [7:0]  dout_q,
	output logic             dout_oe_n_q,
	output logic             ale_q,
	output logic             xen_n_q,
	output logic             xdir_q,
	output logic      [2:0]  ctype_q
);
	bcpu_state_t state_q;
	bcpu_state_t state_d;
	logic [1:0]  idx_q;
	logic [2:0]  t1_cnt_q;
	logic        last;
	logic        in_data;
	logic [2:0]  code;

	assign busy    = (state_q != BCPU_S_IDLE);
	assign last    = ({1'b0, idx_q} == (nbytes - 3'h1));
	assign in_data = (state_d == BCPU_S_T2) || (state_d == BCPU_S_T3) || (state_d == BCPU_S_T4);
	assign code    = is_io ? (is_wr ? CT_IO_WR : CT_IO_RD) : (is_fetch ? CT_FETCH : (is_wr ? CT_MEM_WR : CT_MEM_RD));

	// ****************************************
	// bus phases
	// ****************************************
	always_comb begin
		state_d = state_q;
		case (state_q)
			BCPU_S_IDLE: if (start) state_d = BCPU_S_T1;
			BCPU_S_T1:   state_d = BCPU_S_T2;
			BCPU_S_T2:   state_d = BCPU_S_T3;
			// a slow target holds us in T3, so waits fall before T4
			BCPU_S_T3:   if (ready_s) state_d = BCPU_S_T4;
			BCPU_S_T4:   state_d = last ? BCPU_S_IDLE : BCPU_S_T1;
			default:     state_d = BCPU_S_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) state_q <= BCPU_S_IDLE;
		else        state_q <= state_d;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idx_q  <= 2'h0;
			addr_q <= 20'h0_0000;
		end else if (state_q == BCPU_S_IDLE && start) begin
			idx_q  <= 2'h0;
			addr_q <= base;
		end else if (state_q == BCPU_S_T4) begin
			idx_q  <= idx_q + 2'h1;
			addr_q <= addr_q + 20'h0_0001;
		end
	end

	// low byte rides the lower address, so it lands in the low lane
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)                                rbuf_q <= 32'h0000_0000;
		else if (state_q == BCPU_S_T4 && !is_wr)   rbuf_q[{idx_q, 3'h0} +: 8] <= din_s;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctype_q     <= CT_PASSIVE;
			ale_q       <= 1'b0;
			xen_n_q     <= 1'b1;
			xdir_q      <= 1'b0;
			dout_q      <= 8'h00;
			dout_oe_n_q <= 1'b1;
			done_q      <= 1'b0;
		end else begin
			ctype_q     <= (max_mode && (state_d == BCPU_S_T1 || state_d == BCPU_S_T2 ||
				state_d == BCPU_S_T3)) ? code : CT_PASSIVE;
			ale_q       <= !max_mode && (state_d == BCPU_S_T1);
			xen_n_q     <= !(!max_mode && in_data);
			xdir_q      <= !max_mode && is_wr && (state_d != BCPU_S_IDLE);
			dout_q      <= idx_q[0] ? wdata[15:8] : wdata[7:0];
			dout_oe_n_q <= !(is_wr && in_data);
			done_q      <= (state_q == BCPU_S_T4) && last;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)                                    t1_cnt_q <= 3'h0;
		else if (state_q == BCPU_S_IDLE && start)      t1_cnt_q <= 3'h0;
		else if (state_q == BCPU_S_T1)                 t1_cnt_q <= t1_cnt_q + 3'h1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_phase_walk: assert property (state_q == BCPU_S_T1 |=> state_q == BCPU_S_T2 ##1 state_q == BCPU_S_T3)
		else $error("bus cycle skipped a phase");
	chk_status_code: assert property (state_q == BCPU_S_T1 && max_mode |-> ctype_q == code)
		else $error("cycle type code wrong in T1");
	chk_min_passive: assert property (!max_mode && $past(!max_mode) |-> ctype_q == CT_PASSIVE)
		else $error("status driven in minimum mode");
	chk_byte_count: assert property (done_q |-> t1_cnt_q == $past(nbytes))
		else $error("byte cycle count mismatch");
endmodule
`default_nettype wire

// ===== verilog/bcpu_top.sv
// Behaviour
// - lock pin low bars other masters
// - lock prefix holds lock through next instruction
// - lock pin floats during hold acknowledge
// - queue code shows the clock after operation
// - queue codes: none, first, flush, subsequent
// - twenty-bit byte address, one megabyte space
// - segment base shifted four, offset added
// - fetch code, stack stack, data default
// - string destination uses extra, no override
// - low byte at lower address
// - word operand takes two byte cycles
// - first fetch after reset at entry address
// - lowest kilobyte holds interrupt pointers
// - four-byte pointers, offset then segment, 256
// - strap low selects maximum-mode pin meanings
// - strap high: device drives bus controls
// - maximum mode gives lock, queue, grant; this design has lock and queue pins but no grant pin
// - cycle type codes per bus cycle
// - bus cycle is at least four clocks
`timescale 1ns/1ps
`default_nettype none
module bcpu_top import bcpu_pkg::*; (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic        config_strap,
	input  wire logic        hold_ack,
	input  wire logic        ready_in,
	input  wire logic [7:0]  data_in,
	output logic      [7:0]  data_out,
	output logic             data_oe_n,
	output logic      [19:0] addr_out,
	output logic             ale,
	output logic             xcvr_enable_n,
	output logic             xcvr_direction,
	output logic             cycle_type_bit0,
	output logic             cycle_type_bit1,
	output logic             cycle_type_bit2,
	output logic             lock_n_out,
	output logic             lock_n_oe_n,
	output logic             queue_track_hi,
	output logic             queue_track_lo
);
	// ****************************************
	// reset release and pin synchronisers
	// ****************************************
	logic        rst_meta_q;
	logic        rst_n;
	logic [10:0] sync1_q;
	logic [10:0] sync2_q;
	logic        strap_s;
	logic        hold_s;
	logic        ready_s;
	logic [7:0]  din_s;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= 11'h000;
			sync2_q <= 11'h000;
		end else begin
			sync1_q <= {config_strap, hold_ack, ready_in, data_in};
			sync2_q <= sync1_q;
		end
	end
	assign {strap_s, hold_s, ready_s, din_s} = sync2_q;

	// the strap is a board tie; catching it once avoids mode flips mid-cycle
	logic [1:0] strap_cnt_q;
	logic       max_mode_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_cnt_q <= 2'h0;
			max_mode_q  <= 1'b0;
		end else if (strap_cnt_q != 2'h3) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
			if (strap_cnt_q == 2'h2) max_mode_q <= !strap_s;
		end
	end

	// ****************************************
	// bus slave
	// ****************************************
	logic        acc;
	logic        wr_pend_q;
	logic        rd_pend_q;
	logic [7:0]  a_q;
	logic        wr_ev;

	assign acc   = hsel && hready && htrans[1];
	assign wr_ev = wr_pend_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			a_q       <= 8'h00;
			hreadyout <= 1'b1;
		end else begin
			wr_pend_q <= acc && hwrite;
			rd_pend_q <= acc && !hwrite;
			if (acc) a_q <= haddr[7:0];
			// reads take one wait so they see writes of the prior transfer
			hreadyout <= !(acc && !hwrite);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) hresp <= 1'b0;
		else        hresp <= 1'b0;
	end

	// ****************************************
	// software state
	// ****************************************
	logic [15:0]      seg_cs_q;
	logic [15:0]      seg_ds_q;
	logic [15:0]      seg_es_q;
	logic [15:0]      seg_ss_q;
	logic [15:0]      ip_q;
	logic [15:0]      wdata_q;
	logic [REQ_W-1:0] req_q;
	logic             start_q;
	logic             lock_q;
	logic             fetched_q;
	logic [1:0]       qs_q;
	logic             seq_busy;
	logic             seq_done;
	logic [31:0]      rbuf;
	logic [19:0]      phys;
	logic [19:0]      phys_q;
	logic [2:0]       kind;
	logic [2:0]       nbytes;
	logic             ctrl_wr;
	logic             instr_done;
	logic             lock_set;
	logic [1:0]       qop;

	assign kind       = req_q[REQ_KIND_LSB +: 3];
	assign nbytes     = (kind == KIND_VECTOR) ? 3'h4 : (req_q[REQ_WORD_BIT] ? 3'h2 : 3'h1);
	assign ctrl_wr    = wr_ev && (a_q == REG_CTRL);
	assign lock_set   = ctrl_wr && hwdata[CTRL_LOCK_BIT];
	assign instr_done = ctrl_wr && hwdata[CTRL_DONE_BIT];
	assign qop        = hwdata[CTRL_QOP_LSB +: 2];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seg_cs_q <= RESET_CS;
			seg_ds_q <= 16'h0000;
			seg_es_q <= 16'h0000;
			seg_ss_q <= 16'h0000;
			wdata_q  <= 16'h0000;
		end else if (wr_ev) begin
			if (a_q == REG_SEG_CS)      seg_cs_q <= hwdata[15:0];
			else if (a_q == REG_SEG_DS) seg_ds_q <= hwdata[15:0];
			else if (a_q == REG_SEG_ES) seg_es_q <= hwdata[15:0];
			else if (a_q == REG_SEG_SS) seg_ss_q <= hwdata[15:0];
			else if (a_q == REG_WDATA)  wdata_q  <= hwdata[15:0];
		end
	end

	// fetch pointer: a write loses to the advance of a running fetch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)                                  ip_q <= RESET_IP;
		else if (seq_done && kind == KIND_FETCH)     ip_q <= ip_q + {13'h0000, nbytes};
		else if (wr_ev && a_q == REG_IP && !seq_busy) ip_q <= hwdata[15:0];
	end

	// a request written while the unit is busy is dropped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_q   <= 24'h00_0000;
			start_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			if (wr_ev && a_q == REG_REQ && !seq_busy && !start_q) begin
				req_q   <= hwdata[REQ_W-1:0];
				start_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)       phys_q <= 20'h0_0000;
		else if (start_q) phys_q <= phys;
	end

	// prefix wins over a completion in the same write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)          lock_q <= 1'b0;
		else if (lock_set)   lock_q <= 1'b1;
		else if (instr_done) lock_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)                              fetched_q <= 1'b0;
		else if (start_q && kind == KIND_FETCH)  fetched_q <= 1'b1;
	end

	// ****************************************
	// pins owned here
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			qs_q        <= Q_NOP;
			lock_n_out  <= 1'b1;
			lock_n_oe_n <= 1'b1;
		end else begin
			// code appears the clock after the queue operation
			qs_q        <= (ctrl_wr && fetched_q && max_mode_q) ? qop : Q_NOP;
			lock_n_out  <= !lock_q;
			lock_n_oe_n <= !(max_mode_q && !hold_s);
		end
	end
	assign queue_track_hi = qs_q[1];
	assign queue_track_lo = qs_q[0];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_pend_q) begin
			if (a_q == REG_CTRL)        hrdata <= {31'h0000_0000, lock_q};
			else if (a_q == REG_SEG_CS) hrdata <= {16'h0000, seg_cs_q};
			else if (a_q == REG_SEG_DS) hrdata <= {16'h0000, seg_ds_q};
			else if (a_q == REG_SEG_ES) hrdata <= {16'h0000, seg_es_q};
			else if (a_q == REG_SEG_SS) hrdata <= {16'h0000, seg_ss_q};
			else if (a_q == REG_REQ)    hrdata <= {8'h00, req_q};
			else if (a_q == REG_WDATA)  hrdata <= {16'h0000, wdata_q};
			else if (a_q == REG_RDATA)  hrdata <= rbuf;
			else if (a_q == REG_STATUS) hrdata <= {27'h000_0000, fetched_q, hold_s, max_mode_q, lock_q,
				seq_busy || start_q};
			else if (a_q == REG_PHYS)   hrdata <= {12'h000, phys_q};
			else if (a_q == REG_IP)     hrdata <= {16'h0000, ip_q};
			else                        hrdata <= 32'h0000_0000;
		end
	end

	// ****************************************
	// address forming and bus cycles
	// ****************************************
	logic [2:0] ctype;

	bcpu_seg_addr u_addr (
		.kind    (kind),
		.ovr_en  (req_q[REQ_OVR_BIT]),
		.ovr_seg (req_q[REQ_OSEL_LSB +: 2]),
		.seg_cs  (seg_cs_q),
		.seg_ds  (seg_ds_q),
		.seg_es  (seg_es_q),
		.seg_ss  (seg_ss_q),
		.offset  (req_q[15:0]),
		.ip      (ip_q),
		.phys    (phys)
	);

	bcpu_cycle_seq u_seq (
		.clk         (clk),
		.rst_n       (rst_n),
		.start       (start_q),
		.base        (phys),
		.nbytes      (nbytes),
		.is_wr       (req_q[REQ_WR_BIT] && kind != KIND_FETCH && kind != KIND_VECTOR),
		.is_io       (kind == KIND_IO),
		.is_fetch    (kind == KIND_FETCH),
		.wdata       (wdata_q),
		.max_mode    (max_mode_q),
		.ready_s     (ready_s),
		.din_s       (din_s),
		.busy        (seq_busy),
		.done_q      (seq_done),
		.rbuf_q      (rbuf),
		.addr_q      (addr_out),
		.dout_q      (data_out),
		.dout_oe_n_q (data_oe_n),
		.ale_q       (ale),
		.xen_n_q     (xcvr_enable_n),
		.xdir_q      (xcvr_direction),
		.ctype_q     (ctype)
	);
	assign {cycle_type_bit2, cycle_type_bit1, cycle_type_bit0} = ctype;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_lock_float: assert property (hold_s |=> lock_n_oe_n)
		else $error("lock pin driven in hold acknowledge");
	chk_lock_drive: assert property (lock_q && max_mode_q && !hold_s |=> !lock_n_out && !lock_n_oe_n)
		else $error("lock pin not driven low");
	chk_lock_span: assert property (lock_q && !instr_done |=> lock_q)
		else $error("lock dropped before instruction end");
	chk_queue_next: assert property (ctrl_wr && fetched_q && max_mode_q |=> qs_q == $past(qop))
		else $error("queue code not shown next clock");
	chk_queue_quiet: assert property (!fetched_q |-> qs_q == Q_NOP ##1 qs_q == Q_NOP)
		else $error("queue code before first fetch");
	chk_reset_entry: assert property (start_q && kind == KIND_FETCH && !fetched_q && seg_cs_q == RESET_CS
		&& ip_q == RESET_IP |=> phys_q == RESET_ENTRY)
		else $error("first fetch not at entry address");
	chk_seg_form: assert property (start_q && kind == KIND_DATA && !req_q[REQ_OVR_BIT] |-> phys ==
		20'({seg_ds_q, 4'h0} + {4'h0, req_q[15:0]}))
		else $error("data address not base times sixteen plus offset");
	chk_vector_area: assert property (start_q && kind == KIND_VECTOR |-> phys <= VEC_TOP && phys[1:0] == 2'h0)
		else $error("vector address outside pointer table");
endmodule
`default_nettype wire

// ===== dv/bcpu_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module bcpu_mem_model import bcpu_pkg::*; (
	input  wire logic        clk,
	input  wire logic        slow,
	input  wire logic [19:0] addr_out,
	input  wire logic [7:0]  data_out,
	input  wire logic        data_oe_n,
	input  wire logic        ale,
	input  wire logic [2:0]  ctype,
	input  wire logic        xen_n,
	input  wire logic        xdir,
	output logic             ready_in,
	output logic      [7:0]  data_in,
	output logic      [2:0]  last_ct,
	output logic      [19:0] last_wa,
	output logic      [7:0]  last_wd,
	output logic      [19:0] latched,
	output logic      [3:0]  ncyc,
	output logic             last_dir
);
	// ****************************************
	// memory, latch and decoder side
	// ****************************************
	logic [2:0] prev_ct;
	logic [1:0] wt;
	logic       first;
	initial begin
		ncyc = 4'h0;
		wt = 2'h0;
	end
	// pointer area is always filled; a driven line reads back the inverse, never a stale byte
	assign data_in  = data_oe_n ? (addr_out[7:0] ^ 8'h5A) : ~data_out;
	// a cycle opens with ale or with status leaving passive
	assign first    = ale || (ctype != CT_PASSIVE && prev_ct == CT_PASSIVE);
	// slow mode pulls ready low from T1 on; the pin sync lags two clocks, so it must start early
	assign ready_in = !(slow && (first || wt != 2'h0));
	always @(posedge clk) begin
		prev_ct <= ctype;
		if (ctype != CT_PASSIVE) last_ct <= ctype;
		if (ale) latched <= addr_out;
		if (!xen_n) last_dir <= xdir;
		if (!data_oe_n) begin
			last_wa <= addr_out;
			last_wd <= data_out;
		end
		if (first) begin
			ncyc <= ncyc + 4'h1;
			wt   <= 2'h3;
		end else if (wt != 2'h0) wt <= wt - 2'h1;
	end
endmodule
`default_nettype wire

// ===== dv/tb_bcpu_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bcpu_top import bcpu_pkg::*;;
	logic        clk, rst_b, hsel, hwrite, hready, hreadyout, hresp, slow, strap, hold_ack, ready_in;
	logic        data_oe_n, ale, xen_n, xdir, ct0, ct1, ct2, lock_n, lock_oe_n, q_hi, q_lo, last_dir;
	logic [31:0] haddr, hwdata, hrdata, v;
	logic [1:0]  htrans;
	logic [2:0]  hsize, last_ct;
	logic [7:0]  data_in, data_out, last_wd;
	logic [19:0] addr_out, last_wa, latched;
	logic [3:0]  ncyc, n0;
	int          errors, compares;
	assign hready = hreadyout;
	bcpu_top DUT (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .config_strap(strap), .hold_ack(hold_ack), .ready_in(ready_in),
		.data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .addr_out(addr_out), .ale(ale),
		.xcvr_enable_n(xen_n), .xcvr_direction(xdir), .cycle_type_bit0(ct0), .cycle_type_bit1(ct1),
		.cycle_type_bit2(ct2), .lock_n_out(lock_n), .lock_n_oe_n(lock_oe_n), .queue_track_hi(q_hi),
		.queue_track_lo(q_lo));
	bcpu_mem_model PART (.clk(clk), .slow(slow), .addr_out(addr_out), .data_out(data_out),
		.data_oe_n(data_oe_n), .ale(ale), .ctype({ct2, ct1, ct0}), .ready_in(ready_in), .data_in(data_in),
		.last_ct(last_ct), .last_wa(last_wa), .last_wd(last_wd), .latched(latched), .ncyc(ncyc),
		.xen_n(xen_n), .xdir(xdir), .last_dir(last_dir));
	// ****************************************
	// bus tasks
	// ****************************************
	function automatic logic [31:0] rq(input logic [2:0] k, input logic w, wr, ov, input logic [15:0] off);
		return {8'h00, SEG_ES, ov, wr, w, k, off};
	endfunction
	function automatic logic [7:0] mb(input logic [19:0] a);
		return a[7:0] ^ 8'h5A;
	endfunction
	task automatic cmp(input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (errors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// address phase held until hready, then data phase held until hready
	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'h1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'h1);
		v = hrdata;
	endtask
	task automatic go(input logic [31:0] r, input logic [19:0] pa);
		n0 = ncyc;
		ahb(REG_REQ, 1'h1, r);
		repeat (3) @(posedge clk);
		for (int i = 0; i < 100; i++) begin
			ahb(REG_STATUS, 1'h0, 32'h0);
			if (v[0] === 1'h0) break;
		end
		cmp(32'({hresp, v[0]}), 32'h0);
		ahb(REG_PHYS, 1'h0, 32'h0);
		cmp(32'(v[19:0]), 32'(pa));
		ahb(REG_RDATA, 1'h0, 32'h0);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_fetch();
		ahb(REG_CTRL, 1'h1, 32'h0000_0030);
		#1 cmp(32'({q_hi, q_lo}), 32'h0);
		@(posedge clk);
		go(rq(KIND_FETCH, 1'h0, 1'h0, 1'h0, 16'h0000), 20'hF_FFF0);
		cmp(v & 32'hFF, 32'(mb(20'hF_FFF0)));
		cmp(32'(last_ct), 32'(CT_FETCH));
		for (int q = 1; q < 4; q++) begin
			ahb(REG_CTRL, 1'h1, 32'(q << 4));
			#1 cmp(32'({q_hi, q_lo}), 32'(q));
			@(posedge clk);
			#1 cmp(32'({q_hi, q_lo}), 32'h0);
			@(posedge clk);
		end
	endtask
	task automatic t_seg();
		slow <= 1'h1;
		ahb(REG_SEG_DS, 1'h1, 32'h0000_1234);
		go(rq(KIND_DATA, 1'h1, 1'h0, 1'h0, 16'h0011), 20'h1_2351);
		cmp(v & 32'hFFFF, {16'h0000, mb(20'h1_2352), mb(20'h1_2351)});
		cmp(32'(ncyc - n0), 32'h2);
		cmp(32'(last_ct), 32'(CT_MEM_RD));
		slow <= 1'h0;
	endtask
	task automatic t_str();
		ahb(REG_SEG_ES, 1'h1, 32'h0000_2000);
		ahb(REG_WDATA, 1'h1, 32'h0000_BEEF);
		go(rq(KIND_STRDST, 1'h1, 1'h1, 1'h0, 16'h0010), 20'h2_0010);
		cmp(32'({last_wa, last_wd}), 32'h0200_11BE);
		cmp(32'(last_ct), 32'(CT_MEM_WR));
		go(rq(KIND_DATA, 1'h0, 1'h0, 1'h1, 16'h0005), 20'h2_0005);
		ahb(REG_SEG_SS, 1'h1, 32'h0000_0100);
		go(rq(KIND_STACK, 1'h0, 1'h0, 1'h0, 16'h0002), 20'h0_1002);
		go(rq(KIND_FRAME, 1'h0, 1'h0, 1'h0, 16'h0004), 20'h0_1004);
		go(rq(KIND_IO, 1'h0, 1'h0, 1'h0, 16'h0033), 20'h0_0033);
		cmp(32'(last_ct), 32'(CT_IO_RD));
		go(rq(KIND_IO, 1'h0, 1'h1, 1'h0, 16'h0034), 20'h0_0034);
		cmp(32'(last_ct), 32'(CT_IO_WR));
	endtask
	task automatic t_vec();
		go(rq(KIND_VECTOR, 1'h0, 1'h0, 1'h0, 16'h0002), 20'h0_0008);
		cmp(v, {mb(20'h0_000B), mb(20'h0_000A), mb(20'h0_0009), mb(20'h0_0008)});
		cmp(32'(ncyc - n0), 32'h4);
	endtask
	task automatic t_lock();
		ahb(REG_CTRL, 1'h1, 32'h0000_0001);
		repeat (2) @(posedge clk);
		cmp(32'({lock_n, lock_oe_n}), 32'h0);
		hold_ack <= 1'h1;
		repeat (4) @(posedge clk);
		cmp(32'(lock_oe_n), 32'h1);
		hold_ack <= 1'h0;
		ahb(REG_CTRL, 1'h1, 32'h0000_0002);
		repeat (3) @(posedge clk);
		cmp(32'({lock_n, lock_oe_n}), 32'h2);
	endtask
	task automatic t_min();
		rst_b <= 1'h0;
		strap <= 1'h1;
		repeat (8) @(posedge clk);
		rst_b <= 1'h1;
		repeat (8) @(posedge clk);
		go(rq(KIND_FETCH, 1'h0, 1'h0, 1'h0, 16'h0000), 20'hF_FFF0);
		cmp(32'(latched), 32'h000F_FFF0);
		cmp(32'({ct2, ct1, ct0, lock_oe_n}), 32'hF);
		cmp(32'(last_dir), 32'h0);
		go(rq(KIND_DATA, 1'h0, 1'h1, 1'h0, 16'h0040), 20'h0_0040);
		cmp(32'({last_dir, xdir, xen_n}), 32'h5);
		cmp(32'({last_wa, last_wd}), 32'h0000_4000);
	endtask
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	// watchdog: whole run needs well under this span
	initial begin
		#40000;
		errors++;
		print_verdict();
	end
	initial begin
		{rst_b, hsel, hwrite, strap, hold_ack, slow} = 6'h00;
		{haddr, hwdata, htrans} = 66'h0;
		hsize = 3'h2;
		errors = 0;
		compares = 0;
		repeat (8) @(posedge clk);
		cmp(32'({lock_n, lock_oe_n, q_hi, q_lo}), 32'hC);
		rst_b <= 1'h1;
		repeat (8) @(posedge clk);
		t_fetch();
		t_seg();
		t_str();
		t_vec();
		t_lock();
		t_min();
		print_verdict();
	end
endmodule
`default_nettype wire
